// ### common/asd_pkg.sv
package asd_pkg;
    localparam logic [7:0] ASD_OP_NOP        = 8'h00;
    localparam logic [7:0] ASD_OP_MRESET     = 8'h04;
    localparam logic [7:0] ASD_OP_TXCTRL_WR  = 8'h08;
    localparam logic [7:0] ASD_OP_TXWORD_WR  = 8'h0C;
    localparam logic [7:0] ASD_OP_RX1CTRL_WR = 8'h10;
    localparam logic [7:0] ASD_OP_RX1LBL_WR  = 8'h14;
    localparam logic [7:0] ASD_OP_RX1PLM_WR  = 8'h18;
    localparam logic [7:0] ASD_OP_RX2CTRL_WR = 8'h24;
    localparam logic [7:0] ASD_OP_RX2LBL_WR  = 8'h28;
    localparam logic [7:0] ASD_OP_RX2PLM_WR  = 8'h2C;
    localparam logic [7:0] ASD_OP_FLAG_WR    = 8'h34;
    localparam logic [7:0] ASD_OP_ACLKDIV_WR = 8'h38;
    localparam logic [7:0] ASD_OP_TXSTART    = 8'h40;
    localparam logic [7:0] ASD_OP_SRESET     = 8'h44;
    localparam logic [7:0] ASD_OP_RX1LBL_SET = 8'h48;
    localparam logic [7:0] ASD_OP_RX2LBL_SET = 8'h4C;
    localparam logic [7:0] ASD_OP_TXSTAT_RD  = 8'h80;
    localparam logic [7:0] ASD_OP_TXCTRL_RD  = 8'h84;
    localparam logic [7:0] ASD_OP_RX1STAT_RD = 8'h90;
    localparam logic [7:0] ASD_OP_RX1CTRL_RD = 8'h94;
    localparam logic [7:0] ASD_OP_RX1LBL_RD  = 8'h98;
    localparam logic [7:0] ASD_OP_RX1PLM_RD  = 8'h9C;
    localparam logic [7:0] ASD_OP_RX1FIFO_RD = 8'hA0;
    localparam logic [7:0] ASD_OP_RX1MB1_RD  = 8'hA4;
    localparam logic [7:0] ASD_OP_RX1MB2_RD  = 8'hA8;
    localparam logic [7:0] ASD_OP_RX1MB3_RD  = 8'hAC;
    localparam logic [7:0] ASD_OP_RX2STAT_RD = 8'hB0;

    localparam int         ASD_TX_TRIG_MODE_BIT = 5;
    localparam logic [7:0] ASD_CTRL_RST  = 8'h00;
    localparam logic [255:0] ASD_LBL_RST = 256'h0;
    localparam logic [7:0] ASD_PLM_RST   = 8'h00;

    localparam logic [11:0] ASD_REG_CTRL  = 12'h000;
    localparam logic [11:0] ASD_REG_STAT  = 12'h004;
    localparam logic [11:0] ASD_REG_OPCNT = 12'h008;
    localparam int          ASD_EN_BIT    = 0;
    localparam logic        ASD_EN_RST    = 1'b1;

    typedef enum logic [1:0] {ST_OP, ST_WR, ST_RD, ST_IGN} asd_state_t;

    // Bit 6: op code defined; bits 5:0: data byte count
    function automatic logic [6:0] asd_op_info(input logic [7:0] op);
        case (op)
            ASD_OP_NOP, ASD_OP_MRESET, ASD_OP_TXSTART, ASD_OP_SRESET,
            ASD_OP_RX1LBL_SET, ASD_OP_RX2LBL_SET: return 7'h40;
            ASD_OP_TXCTRL_WR, ASD_OP_RX1CTRL_WR, ASD_OP_RX2CTRL_WR, ASD_OP_FLAG_WR,
            ASD_OP_ACLKDIV_WR, ASD_OP_TXSTAT_RD, ASD_OP_TXCTRL_RD, ASD_OP_RX1STAT_RD,
            ASD_OP_RX1CTRL_RD, ASD_OP_RX2STAT_RD: return 7'h41;
            ASD_OP_RX1PLM_WR, ASD_OP_RX2PLM_WR, ASD_OP_RX1PLM_RD, ASD_OP_RX1MB1_RD,
            ASD_OP_RX1MB2_RD, ASD_OP_RX1MB3_RD: return 7'h43;
            ASD_OP_TXWORD_WR, ASD_OP_RX1FIFO_RD: return 7'h44;
            ASD_OP_RX1LBL_WR, ASD_OP_RX2LBL_WR, ASD_OP_RX1LBL_RD: return 7'h60;
            default: return 7'h00;
        endcase
    endfunction : asd_op_info
endpackage : asd_pkg

// ### hdl/asd_decoder.sv
`timescale 1ns/1ps
module asd_decoder
    import asd_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic              pready,
    output logic              pslverr,
    output logic [31:0]       prdata,
    input  wire logic         cs_n,
    input  wire logic         sclk,
    input  wire logic         si,
    output logic              so,
    input  wire logic [7:0]   tx_status,
    input  wire logic [7:0]   rx1_status,
    input  wire logic [7:0]   rx2_status,
    input  wire logic [31:0]  rx1_fifo_word,
    input  wire logic [23:0]  rx1_mbox1,
    input  wire logic [23:0]  rx1_mbox2,
    input  wire logic [23:0]  rx1_mbox3,
    output logic [7:0]        tx_ctrl,
    output logic [7:0]        rx1_ctrl,
    output logic [7:0]        rx2_ctrl,
    output logic [7:0]        flag_assign,
    output logic [7:0]        aclk_div,
    output logic [255:0]      rx1_labels,
    output logic [255:0]      rx2_labels,
    output logic [23:0]       rx1_plm,
    output logic [23:0]       rx2_plm,
    output logic [31:0]       tx_word,
    output logic              tx_push,
    output logic              tx_start,
    output logic              soft_mreset,
    output logic              fifo_clear,
    output logic              rx1_fifo_pop,
    output logic [2:0]        rx1_mbox_rd
);

    logic [1:0]   cs_s;
    logic [2:0]   sclk_s;
    logic [1:0]   si_s;
    asd_state_t   st_r;
    asd_state_t   st_nxt;
    logic [2:0]   bit_cnt_r;
    logic [5:0]   byte_cnt_r;
    logic [5:0]   len_r;
    logic [7:0]   op_r;
    logic [7:0]   sh_r;
    logic [31:0]  rd_word_r;
    logic [31:0]  rd_cap;
    logic         so_r;
    logic [7:0]   tx_ctrl_r;
    logic [7:0]   rx1_ctrl_r;
    logic [7:0]   rx2_ctrl_r;
    logic [7:0]   flag_r;
    logic [7:0]   aclk_div_r;
    logic [255:0] lbl_r [2];
    logic [7:0]   plm_r [2][3];
    logic [31:0]  tx_word_r;
    logic         tx_push_r;
    logic         tx_start_r;
    logic         soft_mreset_r;
    logic         fifo_clear_r;
    logic         rx1_fifo_pop_r;
    logic [2:0]   rx1_mbox_rd_r;
    logic         ctrl_en_r;
    logic [15:0]  op_cnt_r;
    logic [7:0]   last_op_r;
    logic [31:0]  prdata_r;

    // Pin synchronisers; edges found on the second and third stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_s   <= 2'h3;
            sclk_s <= 3'h0;
            si_s   <= 2'h0;
        end else begin
            cs_s   <= {cs_s[0], cs_n};
            sclk_s <= {sclk_s[1:0], sclk};
            si_s   <= {si_s[0], si};
        end
    end

    wire       frame     = ~cs_s[1] & ctrl_en_r;
    wire       rise      = frame & sclk_s[1] & ~sclk_s[2];
    wire       fall      = frame & ~sclk_s[1] & sclk_s[2];
    wire [7:0] in_byte   = {sh_r[6:0], si_s[1]};
    wire       byte_done = rise && bit_cnt_r == 3'h7;
    wire       op_done   = byte_done && st_r == ST_OP;
    wire       wr_byte   = byte_done && st_r == ST_WR;
    wire [7:0] op_key    = {in_byte[7:2], 2'h0};
    wire [6:0] op_info   = asd_op_info(op_key);
    wire       op_known  = op_info[6];
    wire       op_rd     = op_key[7];
    wire       bit_adv   = (st_r == ST_RD) ? fall : rise;
    wire       byte_adv  = bit_adv && bit_cnt_r == 3'h7 && (st_r == ST_WR || st_r == ST_RD);
    wire       mreset_ev = op_done && op_key == ASD_OP_MRESET;
    wire       sreset_ev = op_done && op_key == ASD_OP_SRESET;
    wire       lbl_rd    = op_r == ASD_OP_RX1LBL_RD;
    wire [7:0] lbl_byte  = lbl_r[0][{~byte_cnt_r[4:0], 3'h0} +: 8];
    wire [7:0] word_byte = rd_word_r[{~byte_cnt_r[1:0], 3'h0} +: 8];
    wire [7:0] rd_byte   = (byte_cnt_r >= len_r) ? 8'h00 : (lbl_rd ? lbl_byte : word_byte);

    always_comb begin
        st_nxt = st_r;
        if (!frame) begin
            st_nxt = ST_OP;
        end else begin
            case (st_r)
                ST_OP: begin
                    if (op_done) begin
                        if (!op_known || op_info[5:0] == 6'h00) begin
                            st_nxt = ST_IGN;
                        end else begin
                            st_nxt = op_rd ? ST_RD : ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (wr_byte && byte_cnt_r == len_r - 6'h01) begin
                        st_nxt = ST_IGN;
                    end
                end
                ST_RD:   st_nxt = ST_RD;
                ST_IGN:  st_nxt = ST_IGN;
                default: st_nxt = ST_OP;
            endcase
        end
    end

    // Frame sequencing; deselect clears the bit and byte counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r       <= ST_OP;
            bit_cnt_r  <= 3'h0;
            byte_cnt_r <= 6'h00;
        end else begin
            st_r <= st_nxt;
            if (!frame) begin
                bit_cnt_r  <= 3'h0;
                byte_cnt_r <= 6'h00;
            end else begin
                if (bit_adv) begin
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                end
                if (op_done) begin
                    byte_cnt_r <= 6'h00;
                end else if (byte_adv && byte_cnt_r != 6'h3F) begin
                    byte_cnt_r <= byte_cnt_r + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r <= 8'h00;
        end else if (rise) begin
            sh_r <= in_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r      <= ASD_OP_NOP;
            len_r     <= 6'h00;
            rd_word_r <= 32'h0;
        end else if (op_done) begin
            op_r      <= op_key;
            len_r     <= op_info[5:0];
            rd_word_r <= rd_cap;
        end
    end

    // Read data captured at op code decode, sent MSB first
    always_comb begin
        case (op_key)
            ASD_OP_TXSTAT_RD:  rd_cap = {tx_status, 24'h0};
            ASD_OP_TXCTRL_RD:  rd_cap = {tx_ctrl_r, 24'h0};
            ASD_OP_RX1STAT_RD: rd_cap = {rx1_status, 24'h0};
            ASD_OP_RX2STAT_RD: rd_cap = {rx2_status, 24'h0};
            ASD_OP_RX1CTRL_RD: rd_cap = {rx1_ctrl_r, 24'h0};
            ASD_OP_RX1PLM_RD:  rd_cap = {plm_r[0][2], plm_r[0][1], plm_r[0][0], 8'h00};
            ASD_OP_RX1FIFO_RD: rd_cap = rx1_fifo_word;
            ASD_OP_RX1MB1_RD:  rd_cap = {rx1_mbox1, 8'h00};
            ASD_OP_RX1MB2_RD:  rd_cap = {rx1_mbox2, 8'h00};
            ASD_OP_RX1MB3_RD:  rd_cap = {rx1_mbox3, 8'h00};
            default:           rd_cap = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_r <= 1'b0;
        end else if (!frame) begin
            so_r <= 1'b0;
        end else if (fall && st_r == ST_RD) begin
            so_r <= rd_byte[~bit_cnt_r];
        end
    end

    // Single-byte registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ctrl_r  <= ASD_CTRL_RST;
            rx1_ctrl_r <= ASD_CTRL_RST;
            rx2_ctrl_r <= ASD_CTRL_RST;
            flag_r     <= ASD_CTRL_RST;
            aclk_div_r <= ASD_CTRL_RST;
        end else if (mreset_ev) begin
            tx_ctrl_r  <= ASD_CTRL_RST;
            rx1_ctrl_r <= ASD_CTRL_RST;
            rx2_ctrl_r <= ASD_CTRL_RST;
            flag_r     <= ASD_CTRL_RST;
            aclk_div_r <= ASD_CTRL_RST;
        end else if (wr_byte) begin
            if (op_r == ASD_OP_TXCTRL_WR) tx_ctrl_r <= in_byte;
            if (op_r == ASD_OP_RX1CTRL_WR) rx1_ctrl_r <= in_byte;
            if (op_r == ASD_OP_RX2CTRL_WR) rx2_ctrl_r <= in_byte;
            if (op_r == ASD_OP_FLAG_WR) flag_r <= in_byte;
            if (op_r == ASD_OP_ACLKDIV_WR) aclk_div_r <= in_byte;
        end
    end

    // Label memory and priority-label filters per receiver
    for (genvar g = 0; g < 2; g++) begin : g_rx
        wire [7:0] op_lbl_wr  = (g == 0) ? ASD_OP_RX1LBL_WR : ASD_OP_RX2LBL_WR;
        wire [7:0] op_lbl_set = (g == 0) ? ASD_OP_RX1LBL_SET : ASD_OP_RX2LBL_SET;
        wire [7:0] op_plm_wr  = (g == 0) ? ASD_OP_RX1PLM_WR : ASD_OP_RX2PLM_WR;
        wire [1:0] plm_idx    = 2'h2 - byte_cnt_r[1:0];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lbl_r[g] <= ASD_LBL_RST;
            end else if (mreset_ev) begin
                lbl_r[g] <= ASD_LBL_RST;
            end else if (op_done && op_key == op_lbl_set) begin
                lbl_r[g] <= '1;
            end else if (wr_byte && op_r == op_lbl_wr) begin
                lbl_r[g][{~byte_cnt_r[4:0], 3'h0} +: 8] <= in_byte;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                plm_r[g] <= '{default: ASD_PLM_RST};
            end else if (mreset_ev || sreset_ev) begin
                plm_r[g] <= '{default: ASD_PLM_RST};
            end else if (wr_byte && op_r == op_plm_wr) begin
                plm_r[g][plm_idx] <= in_byte;
            end
        end
    end

    // Transmit word assembly and one-cycle event pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_word_r      <= 32'h0;
            tx_push_r      <= 1'b0;
            tx_start_r     <= 1'b0;
            soft_mreset_r  <= 1'b0;
            fifo_clear_r   <= 1'b0;
            rx1_fifo_pop_r <= 1'b0;
            rx1_mbox_rd_r  <= 3'h0;
        end else begin
            if (wr_byte && op_r == ASD_OP_TXWORD_WR) begin
                tx_word_r <= {tx_word_r[23:0], in_byte};
            end
            tx_push_r  <= wr_byte && op_r == ASD_OP_TXWORD_WR && byte_cnt_r == 6'h03;
            tx_start_r <= op_done && op_key == ASD_OP_TXSTART
                          && !tx_ctrl_r[ASD_TX_TRIG_MODE_BIT];
            soft_mreset_r  <= mreset_ev;
            fifo_clear_r   <= sreset_ev;
            rx1_fifo_pop_r <= op_done && op_key == ASD_OP_RX1FIFO_RD;
            rx1_mbox_rd_r  <= {op_done && op_key == ASD_OP_RX1MB3_RD,
                               op_done && op_key == ASD_OP_RX1MB2_RD,
                               op_done && op_key == ASD_OP_RX1MB1_RD};
        end
    end

    // APB slave: zero wait states, error on unmapped offsets
    wire        sel_ctrl  = paddr == ASD_REG_CTRL;
    wire        sel_stat  = paddr == ASD_REG_STAT;
    wire        sel_cnt   = paddr == ASD_REG_OPCNT;
    wire        apb_hit   = sel_ctrl | sel_stat | sel_cnt;
    wire        apb_setup = psel & ~penable;
    wire        apb_wr    = psel & penable & pwrite;
    wire [31:0] stat_word = {21'h0, st_r, frame, last_op_r};
    wire [31:0] apb_rmux  = sel_ctrl ? {31'h0, ctrl_en_r} :
                            sel_stat ? stat_word :
                            sel_cnt  ? {16'h0, op_cnt_r} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r <= ASD_EN_RST;
            prdata_r  <= 32'h0;
            op_cnt_r  <= 16'h0;
            last_op_r <= 8'h00;
        end else begin
            if (apb_wr && sel_ctrl && pstrb[0]) begin
                ctrl_en_r <= pwdata[ASD_EN_BIT];
            end
            if (apb_setup && !pwrite) begin
                prdata_r <= apb_rmux;
            end
            if (op_done) begin
                op_cnt_r  <= op_cnt_r + 16'h1;
                last_op_r <= in_byte;
            end
        end
    end

    assign pready       = 1'b1;
    assign pslverr      = psel & penable & ~apb_hit;
    assign prdata       = prdata_r;
    assign so           = so_r;
    assign tx_ctrl      = tx_ctrl_r;
    assign rx1_ctrl     = rx1_ctrl_r;
    assign rx2_ctrl     = rx2_ctrl_r;
    assign flag_assign  = flag_r;
    assign aclk_div     = aclk_div_r;
    assign rx1_labels   = lbl_r[0];
    assign rx2_labels   = lbl_r[1];
    assign rx1_plm      = {plm_r[0][2], plm_r[0][1], plm_r[0][0]};
    assign rx2_plm      = {plm_r[1][2], plm_r[1][1], plm_r[1][0]};
    assign tx_word      = tx_word_r;
    assign tx_push      = tx_push_r;
    assign tx_start     = tx_start_r;
    assign soft_mreset  = soft_mreset_r;
    assign fifo_clear   = fifo_clear_r;
    assign rx1_fifo_pop = rx1_fifo_pop_r;
    assign rx1_mbox_rd  = rx1_mbox_rd_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_noop_idle: assert property (
        op_done && op_key == ASD_OP_NOP |=> st_r == ST_IGN && $stable(tx_ctrl_r) && !tx_push_r)
        else $error("no-op changed state");
    a_mreset_pulse: assert property (
        mreset_ev |=> soft_mreset_r ##1 !soft_mreset_r && tx_ctrl_r == ASD_CTRL_RST)
        else $error("master reset pulse wrong");
    a_tx_start_gate: assert property (
        tx_start_r |-> $past(op_key) == ASD_OP_TXSTART && !$past(tx_ctrl_r[ASD_TX_TRIG_MODE_BIT]))
        else $error("transmit start not gated by trigger mode");
    a_push_word: assert property (
        tx_push_r |-> op_r == ASD_OP_TXWORD_WR && byte_cnt_r == 6'h04)
        else $error("transmit push not after fourth byte");
    a_sreset_clear: assert property (
        sreset_ev |=> fifo_clear_r && plm_r[0][0] == ASD_PLM_RST && plm_r[1][2] == ASD_PLM_RST)
        else $error("software reset incomplete");
    a_label_set: assert property (
        op_done && op_key == ASD_OP_RX1LBL_SET && frame |=> &lbl_r[0])
        else $error("label memory not set");
    a_plm_order: assert property (
        wr_byte && op_r == ASD_OP_RX1PLM_WR && byte_cnt_r == 6'h00 |=> plm_r[0][2] == $past(in_byte))
        else $error("first priority byte not in filter 3");
    a_unknown_ign: assert property (
        op_done && !op_known && frame |=> st_r == ST_IGN)
        else $error("unknown op code not ignored");
    a_cs_abort: assert property (
        !frame |=> st_r == ST_OP && bit_cnt_r == 3'h0 && !so_r)
        else $error("deselect did not end instruction");
    a_so_first: assert property (
        fall && st_r == ST_RD && bit_cnt_r == 3'h0 && byte_cnt_r == 6'h00 |=> so_r == $past(rd_byte[7]))
        else $error("read MSB not driven");

endmodule : asd_decoder

// ### verification/asd_spi_host.sv
`timescale 1ns/1ps
module asd_spi_host (
    input  wire logic pclk,
    output logic      cs_n,
    output logic      sclk,
    output logic      si,
    input  wire logic so
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // One frame of 800 ns clocks; read bits gather in the low end of rd
    task automatic xfer(input logic [7:0] op, input int nb, input logic [255:0] wd,
                        output logic [255:0] rd);
        logic [263:0] bits;
        bits = {op, wd};
        rd = '0;
        @(posedge pclk);
        cs_n <= 1'b0;
        repeat (4) @(posedge pclk);
        for (int i = 0; i < 8 + nb * 8; i++) begin
            si <= bits[263 - i];
            repeat (4) @(posedge pclk);
            sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            if (i >= 8) rd = {rd[254:0], so};
            sclk <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        cs_n <= 1'b1;
        si   <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : xfer
endmodule : asd_spi_host

// ### verification/asd_decoder_tb_top.sv
`timescale 1ns/1ps
module asd_decoder_tb_top;
    import asd_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, cs_n, sclk, si, so;
    logic [11:0]  paddr;
    logic [3:0]   pstrb;
    logic [31:0]  pwdata, prdata, rx1_fifo_word, tx_word, pw, r;
    logic [7:0]   tx_status, rx1_status, rx2_status, tx_ctrl, rx1_ctrl, rx2_ctrl;
    logic [7:0]   flag_assign, aclk_div;
    logic [255:0] rx1_labels, rx2_labels, rd, lbl;
    logic [23:0]  rx1_mbox1, rx1_mbox2, rx1_mbox3, rx1_plm, rx2_plm;
    logic         tx_push, tx_start, soft_mreset, fifo_clear, rx1_fifo_pop, e;
    logic [2:0]   rx1_mbox_rd;
    int           error_cnt, check_count, pc[6];

    asd_decoder asd_decoder_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
        .tx_status(tx_status), .rx1_status(rx1_status), .rx2_status(rx2_status),
        .rx1_fifo_word(rx1_fifo_word), .rx1_mbox1(rx1_mbox1), .rx1_mbox2(rx1_mbox2),
        .rx1_mbox3(rx1_mbox3), .tx_ctrl(tx_ctrl), .rx1_ctrl(rx1_ctrl), .rx2_ctrl(rx2_ctrl),
        .flag_assign(flag_assign), .aclk_div(aclk_div), .rx1_labels(rx1_labels),
        .rx2_labels(rx2_labels), .rx1_plm(rx1_plm), .rx2_plm(rx2_plm), .tx_word(tx_word),
        .tx_push(tx_push), .tx_start(tx_start), .soft_mreset(soft_mreset),
        .fifo_clear(fifo_clear), .rx1_fifo_pop(rx1_fifo_pop), .rx1_mbox_rd(rx1_mbox_rd)
    );
    asd_spi_host asd_spi_host_inst (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));

    always #50 pclk = ~pclk;

    // Pulse counters: push, start, master reset, clear, pop, mailbox read
    always @(posedge pclk) begin
        pc[0] += int'(tx_push === 1'b1);
        pc[1] += int'(tx_start === 1'b1);
        pc[2] += int'(soft_mreset === 1'b1);
        pc[3] += int'(fifo_clear === 1'b1);
        pc[4] += int'(rx1_fifo_pop === 1'b1);
        pc[5] += int'(rx1_mbox_rd !== 3'b000);
        if (tx_push === 1'b1) pw = tx_word;
    end

    task automatic wrap_up;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n == 50) begin
            error_cnt++;
            wrap_up();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic frame(input logic [7:0] op, input int nb, input logic [255:0] wd);
        asd_spi_host_inst.xfer(op, nb, wd, rd);
    endtask : frame

    initial begin
        logic [7:0]  wo[5], ro[5], rv[5];
        logic [23:0] mv[3];
        wo = '{8'h08, 8'h10, 8'h24, 8'h34, 8'h38};
        ro = '{8'h80, 8'h84, 8'h90, 8'h94, 8'hB0};
        rv = '{8'hA5, 8'h41, 8'h3C, 8'h42, 8'hC3};
        mv = '{24'hA1B2C3, 24'hD4E5F6, 24'h071829};
        lbl = {8'hB2, {31{8'h5A}}};
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        {tx_status, rx1_status, rx2_status} = 24'hA53CC3;
        rx1_fifo_word = 32'h12345678;
        {rx1_mbox1, rx1_mbox2, rx1_mbox3} = {mv[0], mv[1], mv[2]};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        chk({e, r}, 33'h100000000);
        for (int k = 0; k < 5; k++) frame(wo[k] | 8'(k % 4), 1, {8'h41 + 8'(k), 248'h0});
        chk({tx_ctrl, rx1_ctrl, rx2_ctrl, flag_assign, aclk_div}, 40'h4142434445);
        for (int k = 0; k < 5; k++) begin
            frame(ro[k], 1, '0);
            chk(rd, rv[k]);
        end
        chk(so, 1'b0);
        frame(8'h40, 0, '0);
        frame(8'h08, 1, {8'h20, 248'h0});
        frame(8'h40, 0, '0);
        chk(pc[1], 1);
        frame(8'h0C, 2, {16'hCAFE, 240'h0});
        chk(pc[0], 0);
        frame(8'h0C, 4, {32'hDEADBEEF, 224'h0});
        chk({pw, 8'(pc[0])}, 40'hDEADBEEF01);
        frame(8'h14, 32, lbl);
        chk(rx1_labels, lbl);
        frame(8'h98, 32, '0);
        chk(rd, lbl);
        frame(8'h4C, 0, '0);
        frame(8'h48, 0, '0);
        chk(rx1_labels, '1);
        chk(rx2_labels, '1);
        frame(8'h28, 32, lbl);
        chk(rx2_labels, lbl);
        frame(8'h18, 3, {24'hAABBCC, 232'h0});
        frame(8'h2C, 3, {24'h112233, 232'h0});
        chk({rx1_plm, rx2_plm}, 48'hAABBCC112233);
        frame(8'h9C, 3, '0);
        chk(rd, 24'hAABBCC);
        frame(8'h44, 0, '0);
        chk({rx1_plm, rx2_plm, 8'(pc[3])}, 56'h1);
        frame(8'hA0, 4, '0);
        chk({rd[31:0], 8'(pc[4])}, 40'h1234567801);
        for (int k = 1; k < 4; k++) begin
            frame(8'hA0 + 8'(4 * k), 3, '0);
            chk(rd, mv[k - 1]);
        end
        chk(pc[5], 3);
        frame(8'h5C, 1, {8'hFF, 248'h0});
        chk(tx_ctrl, 8'h20);
        apb(1'b0, 12'h004, 32'h0);
        chk(r, 32'h5C);
        frame(8'h00, 1, {8'hFF, 248'h0});
        chk(tx_ctrl, 8'h20);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        frame(8'h08, 1, {8'hFF, 248'h0});
        chk(tx_ctrl, 8'h20);
        apb(1'b1, 12'h000, 32'h1);
        frame(8'h04, 0, '0);
        chk({tx_ctrl, rx1_ctrl, 8'(pc[2])}, 24'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(r, 32'h1F);
        wrap_up();
    end
endmodule : asd_decoder_tb_top
